// ---- sqie_map.svh ----
// Register offsets, field positions, reset values for the sequencer interrupt block.
// Assumes inclusion by bare name from the block.
`ifndef SQIE_MAP_SVH
`define SQIE_MAP_SVH
`define SQIE_OFF_SSR      12'h000
`define SQIE_OFF_PSR      12'h004
`define SQIE_OFF_CNT      12'h008
`define SQIE_OFF_WATCH    12'h00c
`define SQIE_OFF_VBASE    12'h010
`define SQIE_OFF_LAST     12'h014
`define SQIE_OFF_IFETCH   12'h018
`define SQIE_OFF_IEXEC    12'h01c
`define SQIE_OFF_ADDRH    12'h020
`define SQIE_OFF_CTRL     12'h024
`define SQIE_B_MALF       0
`define SQIE_B_MALE       1
`define SQIE_B_BRKF       6
`define SQIE_B_BRKC       7
`define SQIE_B_BRKD       8
`define SQIE_B_TIMF       9
`define SQIE_B_TIME       10
`define SQIE_B_SOVF       11
`define SQIE_B_SOVE       12
`define SQIE_B_SUNF       13
`define SQIE_B_SUNE       14
`define SQIE_B_TRPF       15
`define SQIE_B_TRPE       16
`define SQIE_B_PRVF       17
`define SQIE_B_PRVE       18
`define SQIE_B_X4F        19
`define SQIE_B_X4E        20
`define SQIE_B_X23E       21
`define SQIE_B_X2F        22
`define SQIE_B_X3F        23
`define SQIE_B_X1F        24
`define SQIE_B_X1E        25
`define SQIE_B_MEN        26
`define SQIE_B_SP_LO      27
`define SQIE_B_BANK       0
`define SQIE_B_SUPER      0
`define SQIE_SSR_RESET    32'hf800_0000
`define SQIE_SP_EMPTY     5'h1f
`define SQIE_SP_NEARFULL  5'h1d
`define SQIE_VEC_WORDS    64
`define SQIE_RESP_OKAY    2'b00
`define SQIE_RESP_SLVERR  2'b10
`endif

// ---- sqie_pkg.sv ----
// Types shared by the sequencer interrupt block.
package sqie_pkg;
    // Bus slave phases
    typedef enum logic [1:0] {
        SQIE_IDLE = 2'b00,
        SQIE_WRESP = 2'b01,
        SQIE_RRESP = 2'b10
    } sqie_bus_t;

    // Sequencer events from the core, one-cycle pulses
    typedef struct packed {
        logic        push;
        logic        pop;
        logic        trap;
        logic [10:0] trap_imm;
        logic        priv_op;
        logic        misalign;
        logic        code_acc;
        logic [31:0] code_addr;
        logic        data_acc;
        logic [31:0] data_addr;
        logic        retire;
        logic [31:0] retire_addr;
        logic        agen;
        logic [31:0] agen_addr;
        logic [31:0] exec_pc;
        logic [31:0] fetch_pc;
    } sqie_evt_t;

    // Interrupt entry to the core
    typedef struct packed {
        logic        take;
        logic [31:0] vector;
        logic        push_imm;
        logic [10:0] imm;
    } sqie_entry_t;

    // Whole state of the block
    typedef struct packed {
        logic [31:0] ssr;
        logic        bank;
        logic        smode;        // Supervisor mode
        logic [31:0] cnt;
        logic [31:0] watch;
        logic [31:0] vbase;
        logic [31:0] last;
        logic [31:0] ifetch;
        logic [31:0] iexec;
        logic [31:0] addrh;
        logic [3:0]  x_s1;
        logic [3:0]  x_s2;
        sqie_bus_t   bus;
        logic        wa_ok;
        logic        wd_ok;
        logic [11:0] waddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        sqie_entry_t entry;
    } sqie_state_t;
endpackage

// ---- sqie_block.sv ----
// Contract
// - Vector base register locates 64-word table
// - Keep address of last completed instruction
// - Save execute and fetch PCs on entry
// - Hold latest generated address for reissue
// - Bank toggle swaps upper four data registers
// - Stack pointer wraps modulo 32 on push/pop
// - Near-overflow when push hits third-last word
// - Underflow when pop empties the stack
// - Stack pointer sits in status bits 27-31
// - Master enable bit 26 gates all interrupts
// - Internal exception flag/enable bit positions
// - External request flag/enable bit positions
// - Active source sets flag; enables start entry
// - Flags still set with master enable clear
// - Status word access only in supervisor mode
// - Reset clears status except supervisor, pointer
// - Countdown decrements; negative sets its flag
// - Countdown keeps going; supervisor access only
// - Watch address match raises breakpoint flag; code needs BRKC set for code and BRKD for data matches
// - Second and third lines share one enable
// - Sixteen vectors from four source classes
// - Privileged op in user mode flags violation
// - Misaligned load or store sets its flag
// - Trap instruction sets trap flag
// - Supervisor mode on reset and interrupt entry
// - Active-low request lines sampled at rising edges
// - Trap pushes its 11-bit immediate first
//
// Interrupt and exception logic of the sequencer, with an AXI4-Lite register slave.
// Assumes core events arrive as one-cycle pulses on aclk; request lines are asynchronous.
`timescale 1ns/1ps
`include "sqie_map.svh"
module sqie_block
    import sqie_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        first_request_line_n,
    input  wire logic        second_request_line_n,
    input  wire logic        third_request_line_n,
    input  wire logic        fourth_request_line_n,
    input  wire sqie_evt_t   evt,
    input  wire logic        iret,
    output logic             supervisor_mode,
    output logic             bank_select,
    output logic [4:0]       stack_pointer,
    output sqie_entry_t      entry,
    output logic [31:0]      reissue_addr,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    sqie_state_t s_reg;            // Registered state
    sqie_state_t s_next;           // Next state
    logic [31:0] sset;             // Flag set terms this cycle
    logic [3:0]  cls;              // Active-and-enabled classes
    logic        any_en;           // Some enabled flag pending
    logic [31:0] wmask;            // Byte mask of a write
    logic [31:0] wval;             // Merged write value

    // Byte-lane merge helper
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // Next-state logic: flags, counters, entry, bus slave
    always_comb begin
        s_next = s_reg;
        sset = 32'h0000_0000;
        cls = 4'h0;
        any_en = 1'b0;
        wmask = {{8{s_reg.wstrb[3]}}, {8{s_reg.wstrb[2]}}, {8{s_reg.wstrb[1]}}, {8{s_reg.wstrb[0]}}};
        wval = 32'h0000_0000;
        s_next.entry = '0;
        // Two-stage synchronisers, active low inverted after the second stage
        s_next.x_s1 = {fourth_request_line_n, third_request_line_n, second_request_line_n, first_request_line_n};
        s_next.x_s2 = s_reg.x_s1;
        // External sources
        sset[`SQIE_B_X1F] = ~s_reg.x_s2[0];
        sset[`SQIE_B_X2F] = ~s_reg.x_s2[1];
        sset[`SQIE_B_X3F] = ~s_reg.x_s2[2];
        sset[`SQIE_B_X4F] = ~s_reg.x_s2[3];
        // Internal sources
        sset[`SQIE_B_PRVF] = evt.priv_op & ~s_reg.smode;
        sset[`SQIE_B_MALF] = evt.misalign;
        sset[`SQIE_B_TRPF] = evt.trap;
        sset[`SQIE_B_BRKF] = (evt.code_acc & s_reg.ssr[`SQIE_B_BRKC] & (evt.code_addr == s_reg.watch))
                           | (evt.data_acc & s_reg.ssr[`SQIE_B_BRKD] & (evt.data_addr == s_reg.watch));
        // Trap pushes its immediate, so count it as a push
        sset[`SQIE_B_SOVF] = (evt.push | evt.trap) & ~evt.pop
                           & (s_reg.ssr[31:27] + 5'h01 == `SQIE_SP_NEARFULL);
        sset[`SQIE_B_SUNF] = evt.pop & ~(evt.push | evt.trap)
                           & (s_reg.ssr[31:27] == 5'h00);
        // Countdown decrements every cycle without a counter write and keeps running
        s_next.cnt = s_reg.cnt - 32'h0000_0001;
        // Stack pointer, modulo 32 by width
        if ((evt.push | evt.trap) & ~evt.pop) begin
            s_next.ssr[31:27] = s_reg.ssr[31:27] + 5'h01;
        end else if (evt.pop & ~(evt.push | evt.trap)) begin
            s_next.ssr[31:27] = s_reg.ssr[31:27] - 5'h01;
        end
        // Tracking registers
        if (evt.retire) begin
            s_next.last = evt.retire_addr;
        end
        if (evt.agen) begin
            s_next.addrh = evt.agen_addr;
        end
        if (iret) begin
            s_next.smode = 1'b0;
        end
        // Bus slave: accept address and data in either order
        s_next.awready = 1'b0;
        s_next.wready = 1'b0;
        s_next.arready = 1'b0;
        case (s_reg.bus)
            SQIE_IDLE: begin
                if (s_axi_awvalid & ~s_reg.wa_ok & ~s_reg.awready) begin
                    s_next.awready = 1'b1;
                    s_next.wa_ok = 1'b1;
                    s_next.waddr = s_axi_awaddr;
                end
                if (s_axi_wvalid & ~s_reg.wd_ok & ~s_reg.wready) begin
                    s_next.wready = 1'b1;
                    s_next.wd_ok = 1'b1;
                    s_next.wdata = s_axi_wdata;
                    s_next.wstrb = s_axi_wstrb;
                end
                if (s_reg.wa_ok & s_reg.wd_ok) begin
                    // Perform the write; supervisor-only registers refuse user access
                    s_next.bresp = `SQIE_RESP_OKAY;
                    s_next.wa_ok = 1'b0;
                    s_next.wd_ok = 1'b0;
                    s_next.bvalid = 1'b1;
                    s_next.bus = SQIE_WRESP;
                    case (s_reg.waddr)
                        `SQIE_OFF_SSR: begin
                            if (s_reg.smode) begin
                                wval = merge(s_reg.ssr, s_reg.wdata, wmask);
                                s_next.ssr = wval;
                            end else begin
                                s_next.bresp = `SQIE_RESP_SLVERR;
                            end
                        end
                        `SQIE_OFF_CNT: begin
                            if (s_reg.smode) begin
                                s_next.cnt = merge(s_reg.cnt, s_reg.wdata, wmask);
                            end else begin
                                s_next.bresp = `SQIE_RESP_SLVERR;
                            end
                        end
                        `SQIE_OFF_PSR: begin
                            // Bank toggle lives in lane 0 only
                            s_next.bank = s_reg.wstrb[0] ? s_reg.wdata[`SQIE_B_BANK] : s_reg.bank;
                        end
                        `SQIE_OFF_WATCH: s_next.watch = merge(s_reg.watch, s_reg.wdata, wmask);
                        `SQIE_OFF_VBASE: s_next.vbase = merge(s_reg.vbase, s_reg.wdata, wmask);
                        `SQIE_OFF_CTRL:  s_next.smode = s_reg.wstrb[0] ? s_reg.wdata[`SQIE_B_SUPER] : s_reg.smode;
                        `SQIE_OFF_LAST, `SQIE_OFF_IFETCH, `SQIE_OFF_IEXEC, `SQIE_OFF_ADDRH: begin
                            // Read-only: write ignored
                        end
                        default: s_next.bresp = `SQIE_RESP_SLVERR;
                    endcase
                end else if (s_axi_arvalid & ~s_reg.awready & ~s_reg.wready & ~s_reg.wa_ok & ~s_reg.wd_ok) begin
                    // Reads go only when no write is half taken
                    s_next.arready = 1'b1;
                    s_next.rvalid = 1'b1;
                    s_next.rresp = `SQIE_RESP_OKAY;
                    s_next.bus = SQIE_RRESP;
                    case (s_axi_araddr)
                        `SQIE_OFF_SSR: begin
                            s_next.rdata = s_reg.smode ? s_reg.ssr : 32'h0000_0000;
                            s_next.rresp = s_reg.smode ? `SQIE_RESP_OKAY : `SQIE_RESP_SLVERR;
                        end
                        `SQIE_OFF_CNT: begin
                            s_next.rdata = s_reg.smode ? s_reg.cnt : 32'h0000_0000;
                            s_next.rresp = s_reg.smode ? `SQIE_RESP_OKAY : `SQIE_RESP_SLVERR;
                        end
                        `SQIE_OFF_PSR:    s_next.rdata = {31'h0000_0000, s_reg.bank};
                        `SQIE_OFF_WATCH:  s_next.rdata = s_reg.watch;
                        `SQIE_OFF_VBASE:  s_next.rdata = s_reg.vbase;
                        `SQIE_OFF_LAST:   s_next.rdata = s_reg.last;
                        `SQIE_OFF_IFETCH: s_next.rdata = s_reg.ifetch;
                        `SQIE_OFF_IEXEC:  s_next.rdata = s_reg.iexec;
                        `SQIE_OFF_ADDRH:  s_next.rdata = s_reg.addrh;
                        `SQIE_OFF_CTRL:   s_next.rdata = {31'h0000_0000, s_reg.smode};
                        default: begin
                            s_next.rdata = 32'h0000_0000;
                            s_next.rresp = `SQIE_RESP_SLVERR;
                        end
                    endcase
                end
            end
            SQIE_WRESP: begin
                if (s_axi_bready) begin
                    s_next.bvalid = 1'b0;
                    s_next.bus = SQIE_IDLE;
                end
            end
            SQIE_RRESP: begin
                if (s_axi_rready) begin
                    s_next.rvalid = 1'b0;
                    s_next.bus = SQIE_IDLE;
                end
            end
            default: s_next.bus = SQIE_IDLE;
        endcase
        // Flag follows the final counter value, so a write of a negative count raises it too
        // Without this order a freshly written negative count would run with its flag clear
        sset[`SQIE_B_TIMF] = s_next.cnt[31];
        // Hardware sets win over a software write in the same cycle
        s_next.ssr = s_next.ssr | sset;
        // Classes: first line, second/third line, trap, others
        cls[3] = s_next.ssr[`SQIE_B_X1F] & s_next.ssr[`SQIE_B_X1E];
        cls[2] = (s_next.ssr[`SQIE_B_X2F] | s_next.ssr[`SQIE_B_X3F]) & s_next.ssr[`SQIE_B_X23E];
        cls[1] = s_next.ssr[`SQIE_B_TRPF] & s_next.ssr[`SQIE_B_TRPE];
        cls[0] = (s_next.ssr[`SQIE_B_MALF] & s_next.ssr[`SQIE_B_MALE])
               | (s_next.ssr[`SQIE_B_BRKF] & (s_next.ssr[`SQIE_B_BRKC] | s_next.ssr[`SQIE_B_BRKD]))
               | (s_next.ssr[`SQIE_B_TIMF] & s_next.ssr[`SQIE_B_TIME])
               | (s_next.ssr[`SQIE_B_SOVF] & s_next.ssr[`SQIE_B_SOVE])
               | (s_next.ssr[`SQIE_B_SUNF] & s_next.ssr[`SQIE_B_SUNE])
               | (s_next.ssr[`SQIE_B_PRVF] & s_next.ssr[`SQIE_B_PRVE])
               | (s_next.ssr[`SQIE_B_X4F] & s_next.ssr[`SQIE_B_X4E]);
        any_en = |cls;
        // Entry: master enable gates all; entry clears it to avoid re-entry
        // Gate on the registered enable: a write that sets it acts from the next cycle
        // Flags stay up, so a source pending at that write is still honoured one cycle later
        if (any_en & s_reg.ssr[`SQIE_B_MEN]) begin
            s_next.entry.take = 1'b1;
            s_next.entry.vector = s_reg.vbase + {28'h000_0000, cls};
            s_next.ifetch = evt.fetch_pc;
            s_next.iexec = evt.exec_pc;
            s_next.smode = 1'b1;
            s_next.ssr[`SQIE_B_MEN] = 1'b0;
        end
        s_next.entry.push_imm = evt.trap;
        s_next.entry.imm = evt.trap_imm;
    end

    // State register; reset values are constants
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.ssr <= `SQIE_SSR_RESET;
            s_reg.smode <= 1'b1;
            s_reg.x_s1 <= 4'hf;
            s_reg.x_s2 <= 4'hf;
            s_reg.bus <= SQIE_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flip-flops
    assign supervisor_mode = s_reg.smode;
    assign bank_select     = s_reg.bank;
    assign stack_pointer   = s_reg.ssr[31:27];
    assign entry           = s_reg.entry;
    assign reissue_addr    = s_reg.addrh;
    assign s_axi_awready   = s_reg.awready;
    assign s_axi_wready    = s_reg.wready;
    assign s_axi_bvalid    = s_reg.bvalid;
    assign s_axi_bresp     = s_reg.bresp;
    assign s_axi_arready   = s_reg.arready;
    assign s_axi_rvalid    = s_reg.rvalid;
    assign s_axi_rdata     = s_reg.rdata;
    assign s_axi_rresp     = s_reg.rresp;

    // Checks on what the block drives; each label line names the rule it guards

    // Reset leaves only the supervisor bit and the empty stack pointer set
    chk_reset_status: assert property (@(posedge aclk)
        !aresetn |=> s_reg.ssr == `SQIE_SSR_RESET && s_reg.smode)
        else $error("status word reset value wrong");

    // An entry needs the master enable that stood in the cycle it was decided
    chk_men_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        entry.take |-> $past(s_reg.ssr[`SQIE_B_MEN]))
        else $error("entry without master enable");
    chk_entry_super: assert property (@(posedge aclk) disable iff (!aresetn)
        entry.take |-> supervisor_mode)
        else $error("entry left user mode");

    // A lone push moves the pointer up by one unless a status write overrides it
    chk_sp_push: assert property (@(posedge aclk) disable iff (!aresetn)
        (evt.push & ~evt.pop & ~evt.trap & s_reg.bus == SQIE_IDLE & ~(s_reg.wa_ok & s_reg.wd_ok))
        |=> stack_pointer == $past(stack_pointer) + 5'h01)
        else $error("push did not advance pointer");

    // Push from pointer 28 lands in the third-last word
    chk_sov_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        evt.push & ~evt.pop & stack_pointer == 5'h1c |=> s_reg.ssr[`SQIE_B_SOVF])
        else $error("near-overflow flag missing");

    // Pop at pointer 0 takes the last valid word
    chk_sun_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        evt.pop & ~evt.push & ~evt.trap & stack_pointer == 5'h00 |=> s_reg.ssr[`SQIE_B_SUNF])
        else $error("underflow flag missing");

    // Two sync stages plus the flag register: a held low level shows three edges on
    chk_first_request_line_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        !first_request_line_n ##1 !first_request_line_n |=> ##1 s_reg.ssr[`SQIE_B_X1F])
        else $error("first line flag not set");
    chk_count_down: assert property (@(posedge aclk) disable iff (!aresetn)
        !(s_reg.wa_ok & s_reg.wd_ok) |=> s_reg.cnt == $past(s_reg.cnt) - 32'h0000_0001)
        else $error("countdown stalled");
    chk_timer_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.cnt[31] |-> s_reg.ssr[`SQIE_B_TIMF])
        else $error("timer flag missing");
    chk_priv_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        evt.priv_op & ~s_reg.smode |=> s_reg.ssr[`SQIE_B_PRVF])
        else $error("privilege flag missing");
    chk_trap_imm: assert property (@(posedge aclk) disable iff (!aresetn)
        evt.trap |=> entry.push_imm && entry.imm == $past(evt.trap_imm))
        else $error("trap immediate not pushed");
    chk_last_addr: assert property (@(posedge aclk) disable iff (!aresetn)
        evt.retire |=> s_reg.last == $past(evt.retire_addr))
        else $error("last address not kept");
    chk_vector_pos: assert property (@(posedge aclk) disable iff (!aresetn)
        entry.take |-> entry.vector - $past(s_reg.vbase) < 32'd16)
        else $error("vector outside table");

    // Mode is taken from the cycle the read was accepted, as the slave decided it then
    chk_user_ssr: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid & $rose(s_axi_rvalid) & ~$past(supervisor_mode) & $past(s_axi_araddr) == `SQIE_OFF_SSR
        |-> s_axi_rresp == `SQIE_RESP_SLVERR)
        else $error("user read of status allowed");

    // Main scenarios that the bench should reach
    cov_entry: cover property (@(posedge aclk) disable iff (!aresetn) entry.take);
    cov_trap: cover property (@(posedge aclk) disable iff (!aresetn) evt.trap ##[1:4] entry.take);
    cov_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid & s_axi_bready);
    cov_first_request_line: cover property (@(posedge aclk) disable iff (!aresetn) !first_request_line_n ##3 entry.take);
    cov_refuse: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid & s_axi_rresp[1]);
endmodule

// ---- sqie_req_src.sv ----
// Model of the four external interrupt requesters on the far side of the block.
// Assumes the bench names the lines to hold low, bit 0 being the first line.
`timescale 1ns/1ps
module sqie_req_src (
    input  wire logic       aclk,
    input  wire logic [3:0] hold_low,
    output logic      [3:0] lines_n
);
    // Released lines sit at the pull-up level, so idle is all high
    initial lines_n = 4'hf;
    // Change just after an edge and stay put across the next one
    always @(posedge aclk) lines_n <= ~hold_low;
endmodule

// ---- tb.sv ----
// Self-checking bench for the sequencer interrupt block.
// Assumes the request-line model and the block's package in the same folder.
`timescale 1ns/1ps
module tb;
    import sqie_pkg::*;
    logic        aclk, aresetn = 1'b0;
    logic [3:0]  hold = 4'h0, ln;                  // Requests to the model, lines back
    sqie_evt_t   evt = '0, e;                      // Core events and a scratch copy
    sqie_entry_t entry;
    logic        sup, bank, awr, wrd, bv, arr, rv;
    logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [4:0]  sp;
    logic [11:0] awa = 12'h0, ara = 12'h0;
    logic [31:0] reis, rdat, d, vec, wd = 32'h0;
    logic [1:0]  bresp, rresp, rsp;
    logic [10:0] imm;
    int          errors = 0, cmp_count = 0, takes = 0;

    sqie_req_src i_sqie_req_src (.aclk(aclk), .hold_low(hold), .lines_n(ln));
    sqie_block i_sqie_block (.aclk(aclk), .aresetn(aresetn), .first_request_line_n(ln[0]),
        .second_request_line_n(ln[1]), .third_request_line_n(ln[2]), .fourth_request_line_n(ln[3]),
        .evt(evt), .iret(1'b0), .supervisor_mode(sup), .bank_select(bank), .stack_pointer(sp),
        .entry(entry), .reissue_addr(reis), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));

    // 250 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // Entry monitor: counts vector fetches and keeps what they carried
    always @(posedge aclk) begin
        if (entry.take === 1'b1) begin
            takes++;
            vec = entry.vector;
        end
        if (entry.push_imm === 1'b1) imm = entry.imm;
    end

    // One comparison, reported at once when it differs
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Bus write: both halves offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge aclk);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        // Waits for the answer however long it takes; only the watchdog ends a hang
        do begin
            @(posedge aclk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wrd === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        br <= 1'b0;
        rsp = bresp;
    endtask

    // Bus read: data and response taken at the edge where rvalid is seen
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        rr <= 1'b0;
        rsp = rresp;
        d = rdat;
    endtask

    // Core events are single-cycle pulses; a few idle cycles let flags land
    task automatic fire(input sqie_evt_t x);
        @(posedge aclk);
        evt <= x;
        @(posedge aclk);
        evt <= '0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog: the sequence needs a few hundred cycles at most
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h000);
        // The countdown leaves reset at zero and turns negative at once, so its flag is up
        chk("ssr", d, 32'hf800_0200);
        chk("sup", 32'(sup), 1);
        $display("reset test done");
        e = '0;
        e.push = 1'b1;
        fire(e);
        chk("sp wrap", 32'(sp), 0);
        e = '0;
        e.pop = 1'b1;
        fire(e);
        e.pop = 1'b0;
        e.push = 1'b1;
        for (int i = 0; i < 30; i++) fire(e);
        rd(12'h000);
        chk("sunflg", 32'(d[13]), 1);
        chk("sovflg", 32'(d[11]), 1);
        chk("ssr sp", 32'(d[31:27]), 29);
        $display("stack test done");
        hold <= 4'hf;
        repeat (8) @(posedge aclk);
        hold <= 4'h0;
        repeat (4) @(posedge aclk);
        chk("masked takes", takes, 0);
        rd(12'h000);
        chk("ext flags", {d[24], d[23], d[22], d[19]}, 4'hf);
        wr(12'h010, 32'h0000_1000);
        chk("vbase wr", 32'(rsp), 32'(2'b00));
        evt <= '{exec_pc: 32'h0000_0abc, fetch_pc: 32'h0000_0abd, default: '0};
        wr(12'h000, 32'hee00_0000);
        hold <= 4'h1;
        repeat (8) @(posedge aclk);
        hold <= 4'h0;
        chk("first_request_line takes", takes, 1);
        chk("first_request_line vector", vec, 32'h0000_1008);
        rd(12'h01c);
        chk("iexec", d, 32'h0000_0abc);
        rd(12'h018);
        chk("ifetch", d, 32'h0000_0abd);
        $display("external test done");
        wr(12'h000, 32'hec01_0000);
        wr(12'h024, 32'h0);
        chk("user", 32'(sup), 0);
        wr(12'h000, 32'h0000_0000);
        chk("user ssr wr", 32'(rsp), 32'(2'b10));
        rd(12'h000);
        chk("user ssr", 32'(rsp), 32'(2'b10));
        rd(12'h008);
        chk("user cnt", 32'(rsp), 32'(2'b10));
        rd(12'h100);
        chk("unmapped", 32'(rsp), 32'(2'b10));
        e = '0;
        e.priv_op = 1'b1;
        e.misalign = 1'b1;
        fire(e);
        e = '0;
        e.trap = 1'b1;
        e.trap_imm = 11'h5a5;
        fire(e);
        chk("trap vector", vec, 32'h0000_1002);
        chk("trap imm", 32'(imm), 32'h5a5);
        chk("trap sup", 32'(sup), 1);
        rd(12'h000);
        chk("flags", {d[17], d[15], d[0]}, 3'h7);
        $display("user test done");
        // Counter first, so the status write can clear a flag that is no longer raised
        wr(12'h008, 32'h0000_0020);
        wr(12'h000, 32'hf000_0080);
        rd(12'h000);
        chk("tim clear", 32'(d[9]), 0);
        wr(12'h00c, 32'h2000_0040);
        e = '0;
        e.code_acc = 1'b1;
        e.code_addr = 32'h2000_0040;
        e.retire = 1'b1;
        e.retire_addr = 32'h0000_0777;
        e.agen = 1'b1;
        e.agen_addr = 32'h4000_0124;
        fire(e);
        repeat (30) @(posedge aclk);
        rd(12'h000);
        chk("brk tim", {d[9], d[6]}, 2'h3);
        rd(12'h008);
        chk("cnt neg", 32'(d[31]), 1);
        rd(12'h014);
        chk("last", d, 32'h0000_0777);
        chk("reissue", reis, 32'h4000_0124);
        wr(12'h004, 32'h1);
        chk("bank", 32'(bank), 1);
        $display("register test done");
        final_report();
    end
endmodule
